// [pkg/guard_pkg.sv]
// constants, types and register map of the flash section write guard
// What this block does
// RULE1 - store-program from application region is ignored, starts nothing
// RULE2 - store-program from boot loader region may target any flash address
// RULE3 - programming read-while-write region: CPU runs, reads only outside it
// RULE4 - programming no-read-while-write region halts CPU for whole operation
// RULE5 - software avoids read-while-write region while programming is ongoing
// RULE6 - boot loader region always lies inside no-read-while-write region
// RULE7 - busy flag reads one while read-while-write region is blocked
// RULE8 - busy flag stays set after programming until software clears it
// RULE9 - writing the re-enable bit clears the busy flag
// RULE10 - boot size fuses set boundary; each region has own lock pair
// RULE11 - lock bits programmed by software, only chip erase unprograms them (reset also reloads them from the lock pins)
// RULE12 - general lock modes never gate store-program or program loads
// RULE13 - application lock mode 1 places no restriction on accesses
// RULE14 - application lock modes 2 and 3 block store-program writes there
// RULE15 - application lock 3 and 4 block boot-run loads from application
// RULE16 - application lock 3/4, vectors in boot: no interrupts in application
// RULE17 - boot lock mode 1 places no restriction on accesses
// RULE18 - boot lock modes 2 and 3 block store-program writes to boot region
// RULE19 - boot lock modes 3 and 4 block application-run loads from boot
// RULE20 - boot lock 3/4, vectors in application: no interrupts in boot region
// RULE21 - fuses and lock bits sampled at reset, changed only by programming
package guard_pkg;

  localparam int          ADDR_W        = 15;
  localparam int          FLASH_WORDS   = 16384;
  // read-while-write region ends below this word address
  localparam logic [14:0] NO_RW_START   = 15'h3800;
  // boot loader start for each boot size fuse code 0..3
  localparam logic [14:0] BOOT_START_0  = 15'h3800;
  localparam logic [14:0] BOOT_START_1  = 15'h3c00;
  localparam logic [14:0] BOOT_START_2  = 15'h3e00;
  localparam logic [14:0] BOOT_START_3  = 15'h3f00;
  localparam logic [1:0]  LOCK_RESET    = 2'h3;
  localparam int          PROG_CYCLES   = 16;

  // register byte addresses on the bus
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_LOCK      = 4'h4;
  localparam logic [3:0]  REG_STATUS    = 4'h8;

  // control register bit positions
  localparam int          CTRL_REENABLE = 0;
  localparam int          CTRL_ERASE    = 1;
  localparam int          CTRL_VEC_BOOT = 2;

  // lock register bit positions
  localparam int          LK_APP_LO     = 0;
  localparam int          LK_APP_HI     = 1;
  localparam int          LK_BOOT_LO    = 2;
  localparam int          LK_BOOT_HI    = 3;

  // status register bit positions
  localparam int          ST_BUSY       = 0;
  localparam int          ST_HALT       = 1;
  localparam int          ST_ACTIVE     = 2;
  localparam int          ST_REJECT     = 3;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] target;
    logic [ADDR_W-1:0] fetch_pc;
  } store_req_type;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] target;
    logic [ADDR_W-1:0] fetch_pc;
  } load_req_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROG_RW,
    ST_PROG_NO_RW
  } prog_state_type;

endpackage : guard_pkg

// [rtl/flash_section_write_guard.sv]
// flash section write guard: region decode, lock checks, stall and busy
`timescale 1ns/10ps
`default_nettype none
module flash_section_write_guard
  import guard_pkg::*;
#(
  parameter int prog_cycles = PROG_CYCLES
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                sys_rst,
  // fuses and chip erase (pins, synchronised)
  input  wire logic [1:0]          boot_size_fuses,
  input  wire logic [3:0]          lock_fuse_bits,
  input  wire logic                chip_erase,
  // cpu store-program and program-memory load requests
  input  wire store_req_type       store_req,
  input  wire load_req_type        load_req,
  input  wire logic [ADDR_W-1:0]   cpu_pc,
  input  wire logic                cpu_irq_req,
  // cpu controls
  output logic                     cpu_halt,
  output logic                     load_allow,
  output logic                     irq_allow,
  output logic                     prog_start,
  output logic [ADDR_W-1:0]        prog_addr,
  output logic                     prog_erase,
  // avalon-mm slave
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic in_boot(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] start);
    return a >= start;
  endfunction : in_boot

  function automatic logic in_rw_region(input logic [ADDR_W-1:0] a);
    return a < NO_RW_START;
  endfunction : in_rw_region

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] size_s1_q, size_s2_q;
  logic [3:0] lock_s1_q, lock_s2_q;
  logic       erase_s1_q, erase_s2_q;

  always_ff @(posedge clock) begin
    size_s1_q  <= boot_size_fuses;
    size_s2_q  <= size_s1_q;
    lock_s1_q  <= lock_fuse_bits;
    lock_s2_q  <= lock_s1_q;
    erase_s1_q <= chip_erase;
    erase_s2_q <= erase_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fuse capture: taken once after reset so the boundary cannot move
  logic [1:0]        size_q;
  logic [3:0]        lock_q;
  logic              captured_q;
  logic [ADDR_W-1:0] boot_start;
  logic              lock_wr;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      captured_q <= 1'b0;
    end else begin
      captured_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      size_q <= 2'h0;
    end else if (!captured_q) begin
      size_q <= size_s2_q; // [RULE21] [RULE10]
    end
  end

  // locks only move toward programmed (0); chip erase or reset returns them
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lock_q <= {LOCK_RESET, LOCK_RESET};
    end else if (erase_s2_q) begin
      lock_q <= {LOCK_RESET, LOCK_RESET}; // [RULE11]
    end else if (!captured_q) begin
      lock_q <= lock_s2_q; // [RULE21]
    end else if (lock_wr) begin
      lock_q <= lock_q & avs_writedata[3:0]; // [RULE11] [RULE21]
    end
  end

  // every boot start sits at or above the no-rw region start
  always_comb begin
    unique case (size_q)
      2'h0: boot_start = BOOT_START_0; // [RULE6] [RULE10]
      2'h1: boot_start = BOOT_START_1;
      2'h2: boot_start = BOOT_START_2;
      2'h3: boot_start = BOOT_START_3;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock decode; general lock modes are not inputs here at all [RULE12]
  logic app_wr_lock, app_rd_lock, boot_wr_lock, boot_rd_lock;
  logic pc_boot, st_from_boot, st_to_boot, ld_from_boot, ld_to_boot;
  logic store_ok, load_ok, vec_boot_q;
  logic busy_q, ctrl_wr, status_wr;

  assign app_wr_lock  = !lock_q[LK_APP_LO];   // [RULE13] [RULE14]
  assign app_rd_lock  = !lock_q[LK_APP_HI];   // [RULE15]
  assign boot_wr_lock = !lock_q[LK_BOOT_LO];  // [RULE17] [RULE18]
  assign boot_rd_lock = !lock_q[LK_BOOT_HI];  // [RULE19]

  assign st_from_boot = in_boot(store_req.fetch_pc, boot_start);
  assign st_to_boot   = in_boot(store_req.target, boot_start);
  assign ld_from_boot = in_boot(load_req.fetch_pc, boot_start);
  assign ld_to_boot   = in_boot(load_req.target, boot_start);
  assign pc_boot      = in_boot(cpu_pc, boot_start);

  // any target is legal from the boot region, locks permitting
  assign store_ok = st_from_boot // [RULE1] [RULE2]
                    && (st_to_boot ? !boot_wr_lock : !app_wr_lock);

  always_comb begin
    load_ok = 1'b1;
    if (ld_from_boot && !ld_to_boot && app_rd_lock) begin
      load_ok = 1'b0; // [RULE15]
    end else if (!ld_from_boot && ld_to_boot && boot_rd_lock) begin
      load_ok = 1'b0; // [RULE19]
    end
    if (busy_q && in_rw_region(load_req.target)) begin
      load_ok = 1'b0; // [RULE3] [RULE5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming sequencer
  prog_state_type state_q;
  logic [15:0]    count_q;
  logic           reject_q, erase_mode_q;
  logic           accept;

  assign accept = store_req.valid && store_ok && state_q == ST_IDLE;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      count_q <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            count_q <= 16'(prog_cycles - 1);
            state_q <= in_rw_region(store_req.target)
                       ? ST_PROG_RW     // [RULE3]
                       : ST_PROG_NO_RW; // [RULE4]
          end
        end
        ST_PROG_RW, ST_PROG_NO_RW: begin
          if (count_q == 16'h0000) begin
            state_q <= ST_IDLE;
          end else begin
            count_q <= count_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // set wins over the re-enable clear; stays after completion
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else if (accept && in_rw_region(store_req.target)) begin
      busy_q <= 1'b1; // [RULE7] [RULE8]
    end else if (state_q == ST_IDLE && ctrl_wr
                 && avs_writedata[CTRL_REENABLE]) begin
      busy_q <= 1'b0; // [RULE9] [RULE8]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reject_q <= 1'b0;
    end else if (store_req.valid && !store_ok) begin
      reject_q <= 1'b1; // [RULE1]
    end else if (status_wr && avs_writedata[ST_REJECT]) begin
      reject_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu-facing outputs, all registered
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cpu_halt   <= 1'b0;
      prog_start <= 1'b0;
      prog_addr  <= '0;
      prog_erase <= 1'b0;
      load_allow <= 1'b0;
      irq_allow  <= 1'b0;
    end else begin
      cpu_halt   <= (accept && !in_rw_region(store_req.target)) // [RULE4]
                    || (state_q == ST_PROG_NO_RW && count_q != 16'h0000);
      prog_start <= accept; // [RULE1]
      if (accept) begin
        prog_addr  <= store_req.target;
        prog_erase <= erase_mode_q;
      end
      load_allow <= load_req.valid && load_ok;
      // vectors in boot: block in app; vectors in app: block in boot
      irq_allow  <= cpu_irq_req
                    && !(vec_boot_q && !pc_boot && app_rd_lock) // [RULE16]
                    && !(!vec_boot_q && pc_boot && boot_rd_lock); // [RULE20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle, answer on the second
  logic ack_q;
  logic req;

  assign req       = (avs_read || avs_write) && !ack_q;
  assign ctrl_wr   = avs_write && ack_q && avs_address == REG_CTRL;
  assign status_wr = avs_write && ack_q && avs_address == REG_STATUS;
  assign lock_wr   = avs_write && ack_q && avs_address == REG_LOCK
                     && captured_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q           <= req;
      avs_waitrequest <= !req;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vec_boot_q   <= 1'b0;
      erase_mode_q <= 1'b0;
    end else if (ctrl_wr) begin
      vec_boot_q   <= avs_writedata[CTRL_VEC_BOOT];
      erase_mode_q <= avs_writedata[CTRL_ERASE];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req && avs_read) begin
      unique case (avs_address)
        REG_CTRL:   avs_readdata <= {29'h0, vec_boot_q, erase_mode_q, 1'b0};
        REG_LOCK:   avs_readdata <= {28'h0, lock_q};
        REG_STATUS: avs_readdata <= {28'h0, reject_q,
                                     state_q != ST_IDLE,
                                     state_q == ST_PROG_NO_RW,
                                     busy_q}; // [RULE7]
        default:    avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : flash_section_write_guard
`default_nettype wire

// [bench/guard_properties.sv]
// checker: port-level properties of the flash write guard
`timescale 1ns/10ps
`default_nettype none
module guard_checker
  import guard_pkg::*;
#(
  parameter int prog_cycles = PROG_CYCLES
) (
  // clock, reset, lock inputs
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic [3:0]        lock_fuse_bits,
  input wire logic              chip_erase,
  // cpu side
  input wire store_req_type     store_req,
  input wire load_req_type      load_req,
  input wire logic              cpu_halt,
  input wire logic              load_allow,
  input wire logic              prog_start,
  input wire logic [ADDR_W-1:0] prog_addr,
  // register bus
  input wire logic [3:0]        avs_address,
  input wire logic              avs_write,
  input wire logic              avs_read,
  input wire logic [31:0]       avs_writedata,
  input wire logic              avs_waitrequest
);
  logic [3:0] lk_q;
  logic       busy_q;
  logic [7:0] hcnt_q;
  wire logic  wr_ok = avs_write && !avs_waitrequest;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of lock bits; erase may lead the design, which only loosens checks
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lk_q <= lock_fuse_bits;
    end else if (chip_erase) begin
      lk_q <= 4'hf;
    end else if (wr_ok && avs_address == REG_LOCK) begin
      lk_q <= lk_q & avs_writedata[3:0];
    end
  end
  // lags the design by one cycle and clears early: only loosens checks
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else if (prog_start && prog_addr < NO_RW_START) begin
      busy_q <= 1'b1;
    end else if (wr_ok && avs_address == REG_CTRL
                 && avs_writedata[CTRL_REENABLE]) begin
      busy_q <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst || !cpu_halt) begin
      hcnt_q <= 8'h00;
    end else begin
      hcnt_q <= hcnt_q + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_req;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_ans;
    avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_BUS_WAIT: assert property (s_req |-> s_ans)
    else $error("bus answer timing wrong");
  AST_APP_NO_STORE: assert property (
    store_req.valid && store_req.fetch_pc < NO_RW_START |=> !prog_start)
    else $error("store from application started");
  AST_HALT_ON_NO_RW: assert property (
    $rose(cpu_halt) |-> prog_start && prog_addr >= NO_RW_START)
    else $error("halt without store to no-rw region");
  AST_HALT_LEN: assert property (
    $fell(cpu_halt) |-> hcnt_q == prog_cycles)
    else $error("halt length wrong");
  AST_RW_RUNS: assert property (
    prog_start && prog_addr < NO_RW_START |-> !cpu_halt [*4])
    else $error("cpu halted for rw region target");
  AST_RW_LOAD: assert property (
    busy_q && load_req.valid && load_req.target < NO_RW_START |=> !load_allow)
    else $error("rw region load while busy");
  AST_APP_WLOCK: assert property (
    store_req.valid && store_req.target < NO_RW_START && !lk_q[LK_APP_LO]
    |=> !prog_start) else $error("locked app store started");
  AST_BOOT_WLOCK: assert property (
    store_req.valid && store_req.target >= BOOT_START_3 && !lk_q[LK_BOOT_LO]
    |=> !prog_start) else $error("locked boot store started");
  AST_APP_RLOCK: assert property (
    load_req.valid && load_req.fetch_pc >= BOOT_START_3 &&
    load_req.target < NO_RW_START && !lk_q[LK_APP_HI] |=> !load_allow)
    else $error("locked app load allowed");
  AST_BOOT_RLOCK: assert property (
    load_req.valid && load_req.fetch_pc < NO_RW_START &&
    load_req.target >= BOOT_START_3 && !lk_q[LK_BOOT_HI] |=> !load_allow)
    else $error("locked boot load allowed");
endmodule : guard_checker
bind flash_section_write_guard guard_checker #(.prog_cycles(prog_cycles))
  guard_checker_i (.clock(clock), .sys_rst(sys_rst), .chip_erase(chip_erase),
  .lock_fuse_bits(lock_fuse_bits), .store_req(store_req), .load_req(load_req),
  .cpu_halt(cpu_halt), .load_allow(load_allow), .prog_start(prog_start),
  .prog_addr(prog_addr), .avs_address(avs_address), .avs_write(avs_write),
  .avs_read(avs_read), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// [bench/cpu_model.sv]
// cpu core model issuing store-program and program loads
`timescale 1ns/10ps
`default_nettype none
module cpu_model
  import guard_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         cpu_halt,
  output var store_req_type store_req,
  output var load_req_type  load_req,
  output logic [ADDR_W-1:0] cpu_pc,
  output logic              cpu_irq_req
);
  // interrupt kept pending so every gating case is visible
  initial begin
    store_req = '0;
    load_req = '0;
    cpu_pc = BOOT_START_3;
    cpu_irq_req = 1'b1;
  end
  task automatic issue(input logic ld, input logic [ADDR_W-1:0] t, pc,
                       output logic late);
    int n;
    n = 0;
    // a halted core fetches nothing
    do begin
      @(negedge clock);
      n++;
    end while (cpu_halt !== 1'b0 && n < 99);
    // a halt that never ends is reported to the bench as a timeout
    late = (cpu_halt !== 1'b0);
    @(posedge clock);
    cpu_pc <= pc;
    if (ld) load_req <= '{1'b1, t, pc};
    else store_req <= '{1'b1, t, pc};
    @(posedge clock);
    store_req <= '0;
    load_req <= '0;
  endtask : issue
endmodule : cpu_model
`default_nettype wire

// [bench/tb.sv]
// self-checking testbench for the flash section write guard
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR %0t got %0h", $time, a); end end
module tb;
  import guard_pkg::*;
  logic clock, sys_rst, chip_erase, avs_read, avs_write, avs_waitrequest;
  logic [1:0] boot_size_fuses;
  logic [3:0] lock_fuse_bits, avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  store_req_type store_req;
  load_req_type load_req;
  logic [ADDR_W-1:0] cpu_pc, prog_addr;
  logic cpu_irq_req, cpu_halt, load_allow, irq_allow, prog_start, prog_erase;
  int err_count, check_count, n;
  flash_section_write_guard #(.prog_cycles(4)) flash_section_write_guard_i (
    .clock(clock), .sys_rst(sys_rst), .boot_size_fuses(boot_size_fuses),
    .lock_fuse_bits(lock_fuse_bits), .chip_erase(chip_erase),
    .store_req(store_req), .load_req(load_req), .cpu_pc(cpu_pc),
    .cpu_irq_req(cpu_irq_req), .cpu_halt(cpu_halt), .load_allow(load_allow),
    .irq_allow(irq_allow), .prog_start(prog_start), .prog_addr(prog_addr),
    .prog_erase(prog_erase), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  cpu_model cpu_model_i (.clock(clock), .cpu_halt(cpu_halt),
    .store_req(store_req), .load_req(load_req), .cpu_pc(cpu_pc),
    .cpu_irq_req(cpu_irq_req));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic rst(input logic [1:0] f, input logic [3:0] lk);
    @(posedge clock);
    boot_size_fuses <= f;
    lock_fuse_bits <= lk;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : rst
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    // request held until the rising edge that samples waitrequest low
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      test_done();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic go(input logic ld, input logic [ADDR_W-1:0] t, pc);
    logic late;
    cpu_model_i.issue(ld, t, pc, late);
    if (late) begin
      err_count++;
      test_done();
    end
    #1;
  endtask : go
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    chip_erase = 1'b0;
    boot_size_fuses = 2'h3;
    lock_fuse_bits = 4'hf;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_count = 0;
    check_count = 0;
    rst(2'h3, 4'hf);
    bus(0, REG_LOCK, 32'h0);
    `CHK(rd[3:0], 4'hf)
    bus(0, 4'hc, 32'h0);
    `CHK(rd, 32'h0)
    go(0, 15'h0200, 15'h3800);
    `CHK(prog_start, 1'b0)
    bus(0, REG_STATUS, 32'h0);
    `CHK(rd[ST_REJECT], 1'b1)
    bus(1, REG_STATUS, 32'h8);
    go(0, 15'h0200, 15'h3f00);
    `CHK(prog_addr, 15'h0200)
    `CHK(cpu_halt, 1'b0)
    go(1, 15'h0300, 15'h3f00);
    `CHK(load_allow, 1'b0)
    go(1, 15'h3f10, 15'h3f00);
    `CHK(load_allow, 1'b1)
    bus(0, REG_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h1)
    bus(1, REG_CTRL, 32'h1);
    bus(0, REG_STATUS, 32'h0);
    `CHK(rd[ST_BUSY], 1'b0)
    go(1, 15'h0300, 15'h3f00);
    `CHK(load_allow, 1'b1)
    $display("test rw region done");
    bus(1, REG_CTRL, 32'h2);
    go(0, 15'h3f80, 15'h3f00);
    `CHK(prog_erase, 1'b1)
    n = 0;
    while (cpu_halt === 1'b1 && n < 50) begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK(n, 4)
    rst(2'h0, 4'hf);
    go(0, 15'h3810, 15'h3800);
    `CHK(cpu_halt, 1'b1)
    $display("test no-rw region done");
    // boundary for the two middle boot size codes
    rst(2'h1, 4'hf);
    go(0, 15'h0200, 15'h3bff);
    `CHK(prog_start, 1'b0)
    go(0, 15'h0200, 15'h3c00);
    `CHK(prog_start, 1'b1)
    rst(2'h2, 4'hf);
    go(0, 15'h0200, 15'h3dff);
    `CHK(prog_start, 1'b0)
    go(0, 15'h0200, 15'h3e00);
    `CHK(prog_start, 1'b1)
    $display("test boot size done");
    // both lock pairs share the mode code: {upper, lower}
    for (int m = 0; m < 4; m++) begin
      rst(2'h3, {m[1:0], m[1:0]});
      bus(1, REG_CTRL, 32'h4);
      go(1, 15'h3f80, 15'h0100);
      `CHK(load_allow, m[1])
      `CHK(irq_allow, m[1])
      bus(1, REG_CTRL, 32'h0);
      go(1, 15'h0300, 15'h3f00);
      `CHK(load_allow, m[1])
      `CHK(irq_allow, m[1])
      go(0, 15'h3f80, 15'h3f00);
      `CHK(prog_start, m[0])
      go(0, 15'h0200, 15'h3f00);
      `CHK(prog_start, m[0])
      $display("test lock mode %0d done", m);
    end
    rst(2'h3, 4'hf);
    bus(1, REG_LOCK, 32'he);
    bus(1, REG_LOCK, 32'hf);
    bus(0, REG_LOCK, 32'h0);
    `CHK(rd[3:0], 4'he)
    go(0, 15'h0200, 15'h3f00);
    `CHK(prog_start, 1'b0)
    @(posedge clock);
    chip_erase <= 1'b1;
    repeat (4) @(posedge clock);
    chip_erase <= 1'b0;
    bus(0, REG_LOCK, 32'h0);
    `CHK(rd[3:0], 4'hf)
    $display("test lock bits done");
    test_done();
  end
endmodule : tb
`default_nettype wire
